// ### src/hmsr_pkg.sv
// Shared constants and types for the host miscellaneous status registers.
// Assumes a single 100 MHz system clock and an SRAM-like host bus.
package hmsr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_TIMER_CONFIG = 8'h8c;
	localparam logic [7:0] OFS_TIMER_COUNT = 8'h90;
	localparam logic [7:0] OFS_HALF_ORDER = 8'h98;
	localparam logic [7:0] OFS_TICK_COUNT = 8'h9c;
	localparam logic [7:0] OFS_DROP_COUNT = 8'ha0;
	localparam logic [7:0] OFS_MAC_CMD = 8'ha4;
	localparam logic [7:0] OFS_MAC_DATA = 8'ha8;

	// Field positions
	localparam int unsigned CMD_BUSY_BIT = 31;
	localparam int unsigned CMD_RNW_BIT = 30;
	localparam int unsigned TMR_EN_BIT = 29;
	localparam int unsigned DROP_MID_BIT = 31;

	// Reset and special values
	localparam logic [15:0] TIMER_RESET = 16'hffff;
	localparam logic [31:0] HALF_ORDER_RESET = 32'h00000000;
	localparam logic [31:0] HALF_ORDER_SWAP = 32'hffffffff;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;
	localparam logic [15:0] HALF_ZERO = 16'h0000;
	localparam logic [7:0] MAC_ADDR_RESET = 8'h00;

	// Timing
	localparam int unsigned SYS_CLK_HZ = 100_000_000;
	localparam int unsigned TICK_HZ = 25_000_000;
	localparam int unsigned TICK_DIV = SYS_CLK_HZ / TICK_HZ;

	typedef struct packed {
		logic [7:0] addr;
		logic rnw;
		logic [31:0] wdata;
	} hmsr_mac_req_type;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} hmsr_half_type;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} hmsr_word_type;

	typedef enum logic [1:0] {
		MAC_IDLE,
		MAC_WAIT_ACK,
		MAC_WAIT_RELEASE
	} hmsr_mac_state_type;
endpackage : hmsr_pkg

// ### src/hmsr_half_path.sv
// Half-word ordering between 32-bit data FIFO words and the 16-bit network side.
// Assumes the FIFO side holds tx words steady until taken.
`timescale 1ns/1ps
module hmsr_half_path (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Async reset, active high
	input wire hmsr_pkg::hmsr_word_type tx_word, // Word from transmit FIFO
	output logic tx_word_ready, // Word taken this cycle
	output hmsr_pkg::hmsr_half_type tx_half, // Half-word to network
	input wire logic tx_half_ready, // Network takes half-word
	input wire hmsr_pkg::hmsr_half_type rx_half, // Half-word from network
	output hmsr_pkg::hmsr_word_type rx_word // Packed word to receive FIFO
);
	logic tx_hi_pend_q;
	logic [15:0] tx_hi_q;
	hmsr_pkg::hmsr_half_type tx_out_q;
	logic tx_free;
	logic rx_have_lo_q;
	logic [15:0] rx_lo_q;
	hmsr_pkg::hmsr_word_type rx_word_q;

	assign tx_free = !tx_out_q.valid || tx_half_ready;
	assign tx_word_ready = tx_word.valid && !tx_hi_pend_q && tx_free;
	assign tx_half = tx_out_q;
	assign rx_word = rx_word_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_out_q <= '0;
			tx_hi_q <= hmsr_pkg::HALF_ZERO;
			tx_hi_pend_q <= 1'b0;
		end else if (tx_free) begin
			if (tx_word_ready) begin
				tx_out_q <= {1'b1, tx_word.data[15:0]};
				tx_hi_q <= tx_word.data[31:16];
				tx_hi_pend_q <= 1'b1;
			end else if (tx_hi_pend_q) begin
				tx_out_q <= {1'b1, tx_hi_q};
				tx_hi_pend_q <= 1'b0;
			end else begin
				tx_out_q.valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_lo_q <= hmsr_pkg::HALF_ZERO;
			rx_have_lo_q <= 1'b0;
			rx_word_q <= '0;
		end else begin
			rx_word_q.valid <= 1'b0;
			if (rx_half.valid && !rx_have_lo_q) begin
				rx_lo_q <= rx_half.data;
				rx_have_lo_q <= 1'b1;
			end else if (rx_half.valid) begin
				rx_word_q <= {1'b1, rx_half.data, rx_lo_q};
				rx_have_lo_q <= 1'b0;
			end
		end
	end
endmodule : hmsr_half_path

// ### src/hmsr_regs.sv
// Host miscellaneous status registers: timer, half-word order, tick counter,
// dropped-frame counter and indirect MAC register access.
// Assumes host bus strobes synchronous to sys_clk; MAC side answers with a level ack.
`timescale 1ns/1ps
module hmsr_regs #(
	parameter int unsigned TIMER_TICK_CYCLES = 10000 // Cycles per timer decrement
) (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic sys_rst, // Async reset, active high
	input wire logic bus_16bit, // Host bus is 16 bits wide
	input wire logic host_cs_n, // Chip select, active low
	input wire logic host_rd_n, // Read strobe, active low
	input wire logic host_wr_n, // Write strobe, active low
	input wire logic [7:1] host_addr, // Host address
	input wire logic [31:0] host_din, // Host data in
	output logic [31:0] host_dout, // Host read data
	output logic host_dout_oe, // Host data driven
	input wire logic rx_frame_dropped, // Pulse per discarded frame
	output logic drop_midpoint_event, // Pulse on count midpoint
	output logic mac_req, // Indirect access request
	output hmsr_pkg::hmsr_mac_req_type mac_cmd, // Indirect access details
	input wire logic mac_ack, // Indirect access acknowledge
	input wire logic [31:0] mac_rdata, // MAC register read value
	input wire hmsr_pkg::hmsr_word_type tx_word, // Transmit FIFO word
	output logic tx_word_ready, // Transmit word taken
	output hmsr_pkg::hmsr_half_type tx_half, // Half-word to network
	input wire logic tx_half_ready, // Network takes half-word
	input wire hmsr_pkg::hmsr_half_type rx_half, // Half-word from network
	output hmsr_pkg::hmsr_word_type rx_word // Word to receive FIFO
);
	localparam int unsigned TDW = $clog2(TIMER_TICK_CYCLES + 1);
	localparam int unsigned FDW = $clog2(hmsr_pkg::TICK_DIV + 1);
	localparam logic [TDW-1:0] TICK_LAST = TDW'(TIMER_TICK_CYCLES - 1);
	localparam logic [FDW-1:0] FR_LAST = FDW'(hmsr_pkg::TICK_DIV - 1);

	logic rd_prev_q;
	logic wr_prev_q;
	logic rd_start;
	logic wr_start;
	logic [7:0] word_addr;
	logic hi_sel;
	logic wr_hi;
	logic wr_lo;
	logic [31:0] wdata;
	logic [31:0] live_rdata;
	logic [31:0] rsel;
	logic snap_reg;
	logic snap_first;
	logic [31:0] snap_q;
	logic snap_vld_q;
	logic [7:0] snap_addr_q;
	logic [31:0] host_dout_q;
	logic tmr_en_q;
	logic [15:0] tmr_load_q;
	logic [15:0] tmr_count_q;
	logic [TDW-1:0] tmr_div_q;
	logic [FDW-1:0] fr_div_q;
	logic [31:0] tick_count_value_q;
	logic [31:0] half_order_q;
	logic [31:0] dropped_frame_tally_q;
	logic drop_clear;
	logic drop_event_q;
	hmsr_pkg::hmsr_mac_state_type mac_state_q;
	logic mac_req_q;
	logic access_pending;
	logic read_not_write_q;
	logic [7:0] mac_addr_q;
	logic [31:0] mac_indirect_data_q;
	logic cmd_wr;
	logic data_wr;
	logic cfg_wr;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
		input logic hi, input logic lo);
		merge = {hi ? nv[31:16] : old[31:16], lo ? nv[15:0] : old[15:0]};
	endfunction : merge

	// Host strobes act once, on their assertion edge
	assign rd_start = !host_cs_n && !host_rd_n && !rd_prev_q;
	assign wr_start = !host_cs_n && !host_wr_n && !wr_prev_q;
	assign word_addr = {host_addr[7:2], 2'b00};

	assign hi_sel = bus_16bit && (host_addr[1] ^ (half_order_q == hmsr_pkg::HALF_ORDER_SWAP));
	assign wr_hi = !bus_16bit || hi_sel;
	assign wr_lo = !bus_16bit || !hi_sel;
	assign wdata = bus_16bit ? {host_din[15:0], host_din[15:0]} : host_din;

	assign access_pending = mac_state_q != hmsr_pkg::MAC_IDLE;
	assign cfg_wr = wr_start && word_addr == hmsr_pkg::OFS_TIMER_CONFIG;
	assign cmd_wr = wr_start && word_addr == hmsr_pkg::OFS_MAC_CMD && !access_pending;
	assign data_wr = wr_start && word_addr == hmsr_pkg::OFS_MAC_DATA && !access_pending;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= !host_cs_n && !host_rd_n;
			wr_prev_q <= !host_cs_n && !host_wr_n;
		end
	end

	// Read decode
	always_comb begin
		live_rdata = hmsr_pkg::WORD_ZERO;
		if (word_addr == hmsr_pkg::OFS_TIMER_CONFIG) begin
			live_rdata[hmsr_pkg::TMR_EN_BIT] = tmr_en_q;
			live_rdata[15:0] = tmr_load_q;
		end else if (word_addr == hmsr_pkg::OFS_TIMER_COUNT) begin
			live_rdata[15:0] = tmr_count_q;
		end else if (word_addr == hmsr_pkg::OFS_HALF_ORDER) begin
			live_rdata = half_order_q;
		end else if (word_addr == hmsr_pkg::OFS_TICK_COUNT) begin
			live_rdata = tick_count_value_q;
		end else if (word_addr == hmsr_pkg::OFS_DROP_COUNT) begin
			live_rdata = dropped_frame_tally_q;
		end else if (word_addr == hmsr_pkg::OFS_MAC_CMD) begin
			live_rdata[hmsr_pkg::CMD_BUSY_BIT] = access_pending;
			live_rdata[hmsr_pkg::CMD_RNW_BIT] = read_not_write_q;
			live_rdata[7:0] = mac_addr_q;
		end else if (word_addr == hmsr_pkg::OFS_MAC_DATA) begin
			live_rdata = mac_indirect_data_q;
		end
	end

	assign snap_reg = word_addr == hmsr_pkg::OFS_TICK_COUNT
		|| word_addr == hmsr_pkg::OFS_DROP_COUNT;
	assign snap_first = !(snap_vld_q && snap_addr_q == word_addr);
	assign rsel = (bus_16bit && snap_reg && !snap_first) ? snap_q : live_rdata;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			snap_q <= hmsr_pkg::WORD_ZERO;
			snap_vld_q <= 1'b0;
			snap_addr_q <= hmsr_pkg::MAC_ADDR_RESET;
		end else if (rd_start && bus_16bit && snap_reg) begin
			snap_q <= live_rdata;
			snap_addr_q <= word_addr;
			snap_vld_q <= snap_first;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_dout_q <= hmsr_pkg::WORD_ZERO;
		end else if (rd_start) begin
			host_dout_q <= !bus_16bit ? rsel
				: {hmsr_pkg::HALF_ZERO, hi_sel ? rsel[31:16] : rsel[15:0]};
		end
	end

	assign host_dout = host_dout_q;
	assign host_dout_oe = !host_cs_n && !host_rd_n;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			half_order_q <= hmsr_pkg::HALF_ORDER_RESET;
		end else if (wr_start && word_addr == hmsr_pkg::OFS_HALF_ORDER) begin
			half_order_q <= merge(half_order_q, wdata, wr_hi, wr_lo);
		end
	end

	// Timer configuration
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tmr_en_q <= 1'b0;
			tmr_load_q <= hmsr_pkg::TIMER_RESET;
		end else if (cfg_wr) begin
			if (wr_hi) begin
				tmr_en_q <= wdata[hmsr_pkg::TMR_EN_BIT];
			end
			if (wr_hi && tmr_en_q && !wdata[hmsr_pkg::TMR_EN_BIT]) begin
				tmr_load_q <= hmsr_pkg::TIMER_RESET;
			end else if (wr_lo) begin
				tmr_load_q <= wdata[15:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tmr_count_q <= hmsr_pkg::TIMER_RESET;
			tmr_div_q <= '0;
		end else if (!tmr_en_q) begin
			tmr_div_q <= '0;
			if (cfg_wr && wr_hi && wdata[hmsr_pkg::TMR_EN_BIT]) begin
				tmr_count_q <= cfg_wr && wr_lo ? wdata[15:0] : tmr_load_q;
			end
		end else if (tmr_div_q == TICK_LAST) begin
			tmr_div_q <= '0;
			tmr_count_q <= tmr_count_q == hmsr_pkg::HALF_ZERO ? tmr_load_q
				: tmr_count_q - 16'h0001;
		end else begin
			tmr_div_q <= tmr_div_q + TDW'(1);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fr_div_q <= '0;
			tick_count_value_q <= hmsr_pkg::WORD_ZERO;
		end else if (fr_div_q == FR_LAST) begin
			fr_div_q <= '0;
			tick_count_value_q <= tick_count_value_q + 32'h00000001;
		end else begin
			fr_div_q <= fr_div_q + FDW'(1);
		end
	end

	assign drop_clear = rd_start && word_addr == hmsr_pkg::OFS_DROP_COUNT
		&& (!bus_16bit || snap_first);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dropped_frame_tally_q <= hmsr_pkg::WORD_ZERO;
		end else if (drop_clear) begin
			// A drop in the clearing cycle is kept
			dropped_frame_tally_q <= {31'h00000000, rx_frame_dropped};
		end else if (rx_frame_dropped) begin
			dropped_frame_tally_q <= dropped_frame_tally_q + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			drop_event_q <= 1'b0;
		end else begin
			drop_event_q <= rx_frame_dropped && !drop_clear
				&& !dropped_frame_tally_q[hmsr_pkg::DROP_MID_BIT]
				&& (&dropped_frame_tally_q[hmsr_pkg::DROP_MID_BIT-1:0]);
		end
	end

	assign drop_midpoint_event = drop_event_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			read_not_write_q <= 1'b0;
			mac_addr_q <= hmsr_pkg::MAC_ADDR_RESET;
		end else if (cmd_wr) begin
			if (wr_hi) begin
				read_not_write_q <= wdata[hmsr_pkg::CMD_RNW_BIT];
			end
			if (wr_lo) begin
				mac_addr_q <= wdata[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mac_indirect_data_q <= hmsr_pkg::WORD_ZERO;
		end else if (mac_state_q == hmsr_pkg::MAC_WAIT_ACK && mac_ack && read_not_write_q) begin
			mac_indirect_data_q <= mac_rdata;
		end else if (data_wr) begin
			mac_indirect_data_q <= merge(mac_indirect_data_q, wdata, wr_hi, wr_lo);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mac_state_q <= hmsr_pkg::MAC_IDLE;
			mac_req_q <= 1'b0;
		end else begin
			case (mac_state_q)
				hmsr_pkg::MAC_IDLE: begin
					if (cmd_wr && wr_hi && wdata[hmsr_pkg::CMD_BUSY_BIT]) begin
						mac_req_q <= 1'b1;
						mac_state_q <= hmsr_pkg::MAC_WAIT_ACK;
					end
				end
				hmsr_pkg::MAC_WAIT_ACK: begin
					if (mac_ack) begin
						mac_req_q <= 1'b0;
						mac_state_q <= hmsr_pkg::MAC_WAIT_RELEASE;
					end
				end
				hmsr_pkg::MAC_WAIT_RELEASE: begin
					if (!mac_ack) begin
						mac_state_q <= hmsr_pkg::MAC_IDLE;
					end
				end
				default: begin
					mac_state_q <= hmsr_pkg::MAC_IDLE;
				end
			endcase
		end
	end

	assign mac_req = mac_req_q;
	assign mac_cmd = '{addr: mac_addr_q, rnw: read_not_write_q, wdata: mac_indirect_data_q};

	hmsr_half_path u_half_path (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tx_word(tx_word),
		.tx_word_ready(tx_word_ready),
		.tx_half(tx_half),
		.tx_half_ready(tx_half_ready),
		.rx_half(rx_half),
		.rx_word(rx_word)
	);
endmodule : hmsr_regs

// ### src/hmsr_regs_note_unused.sv
// Holds no logic: the register block is hmsr_regs with its hmsr_half_path.
// Assumes nothing of its surroundings; kept empty so no stray module elaborates.

// ### testbench/hmsr_regs_assertions.sv
// Port checks for the status register block.
// Bound to every instance of the register block.
`timescale 1ns/1ps
module hmsr_regs_assertions (
	input wire logic sys_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic bus_16bit, // Bus width
	input wire logic host_cs_n, // Select
	input wire logic host_wr_n, // Write
	input wire logic [7:1] host_addr, // Address
	input wire logic [31:0] host_din, // Data
	input wire logic rx_frame_dropped, // Drop
	input wire logic drop_midpoint_event, // Midpoint
	input wire logic mac_req, // Request
	input wire hmsr_pkg::hmsr_mac_req_type mac_cmd, // Command
	input wire logic mac_ack, // Ack
	input wire hmsr_pkg::hmsr_word_type tx_word, // Tx word
	input wire logic tx_word_ready, // Taken
	input wire hmsr_pkg::hmsr_half_type tx_half, // Tx half
	input wire hmsr_pkg::hmsr_half_type rx_half, // Rx half
	input wire hmsr_pkg::hmsr_word_type rx_word // Rx word
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	AST_START: assert property ($rose(mac_req) |-> !$past(host_cs_n) &&
		!$past(host_wr_n) && ($past(host_addr) | 7'h01) == 7'h53) else $error("stray request");
	AST_CMD: assert property ($rose(mac_req) && !bus_16bit |->
		{1'b0, mac_cmd.rnw, 22'h000000, mac_cmd.addr} == ($past(host_din) & 32'h400000ff))
		else $error("command fields wrong");
	AST_HOLD: assert property (mac_req && !mac_ack |=> mac_req)
		else $error("request dropped early");
	AST_DROP: assert property (mac_req && mac_ack |=> !mac_req)
		else $error("request held after ack");
	AST_STABLE: assert property (mac_req && $past(mac_req) |-> $stable(mac_cmd))
		else $error("command moved");
	AST_TXLO: assert property (tx_word.valid && tx_word_ready |=>
		tx_half == {1'b1, 16'($past(tx_word))}) else $error("low half not first");
	AST_RXPACK: assert property (rx_word.valid |->
		$past(rx_half) == {1'b1, rx_word.data[31:16]}) else $error("rx packing wrong");
	AST_MID: assert property (drop_midpoint_event |->
		$past(rx_frame_dropped) ##1 !drop_midpoint_event) else $error("midpoint pulse wrong");
	cover property (mac_req && mac_ack && mac_cmd.rnw);
	cover property (tx_word.valid && tx_word_ready);
	cover property (rx_word.valid);
endmodule : hmsr_regs_assertions
bind hmsr_regs hmsr_regs_assertions u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.bus_16bit(bus_16bit), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
	.host_addr(host_addr), .host_din(host_din), .rx_frame_dropped(rx_frame_dropped),
	.drop_midpoint_event(drop_midpoint_event), .mac_req(mac_req), .mac_cmd(mac_cmd),
	.mac_ack(mac_ack), .tx_word(tx_word), .tx_word_ready(tx_word_ready),
	.tx_half(tx_half), .rx_half(rx_half), .rx_word(rx_word));

// ### testbench/hmsr_mac_model.sv
// Behavioural MAC side answering the four-phase indirect access.
// Assumes requests arrive in the same clock domain.
`timescale 1ns/1ps
module hmsr_mac_model (
	input wire logic sys_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic mac_req, // Request
	input wire hmsr_pkg::hmsr_mac_req_type mac_cmd, // Command
	input wire logic [7:0] lat, // Answer delay
	output logic mac_ack, // Acknowledge
	output logic [31:0] mac_rdata // Read value
);
	logic [31:0] mem_q [256];
	logic [7:0] wait_q;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mac_ack <= 1'b0;
			mac_rdata <= 32'h5a5a5a5a;
			wait_q <= 8'h00;
		end else if (mac_req && !mac_ack && wait_q != lat) begin
			wait_q <= wait_q + 8'h01;
		end else if (mac_req && !mac_ack) begin
			mac_ack <= 1'b1;
			wait_q <= 8'h00;
			mac_rdata <= mac_cmd.rnw ? mem_q[mac_cmd.addr] : ~mac_rdata;
		end else if (!mac_req && mac_ack) begin
			mac_ack <= 1'b0;
			mac_rdata <= ~mac_rdata;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (mac_req && !mac_ack && wait_q == lat && !mac_cmd.rnw) begin
			mem_q[mac_cmd.addr] <= mac_cmd.wdata;
		end
	end
endmodule : hmsr_mac_model

// ### testbench/hmsr_regs_tb.sv
// Self-checking bench for the status register block.
// Assumes the MAC model on the indirect access link.
`timescale 1ns/1ps
module hmsr_regs_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic bus_16bit = 1'b0;
	logic host_cs_n = 1'b1;
	logic host_rd_n = 1'b1;
	logic host_wr_n = 1'b1;
	logic [7:1] host_addr = 7'h00;
	logic [31:0] host_din = 32'h00000000;
	logic [31:0] host_dout;
	logic rx_frame_dropped = 1'b0;
	logic mac_req;
	hmsr_pkg::hmsr_mac_req_type mac_cmd;
	logic mac_ack;
	logic [31:0] mac_rdata;
	logic [7:0] lat = 8'h00;
	hmsr_pkg::hmsr_word_type tx_word = '0;
	logic tx_word_ready;
	hmsr_pkg::hmsr_half_type tx_half;
	logic tx_half_ready = 1'b0;
	hmsr_pkg::hmsr_half_type rx_half = '0;
	hmsr_pkg::hmsr_word_type rx_word;
	logic [31:0] d;
	logic [31:0] v;
	logic oe;
	logic mid;
	logic saw_mid = 1'b0;
	logic [7:0] ra [7] = '{8'h8c, 8'h90, 8'h98, 8'ha0, 8'ha4, 8'ha8, 8'hb0};
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	hmsr_regs #(.TIMER_TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.bus_16bit(bus_16bit), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_addr(host_addr), .host_din(host_din),
		.host_dout(host_dout), .host_dout_oe(oe), .rx_frame_dropped(rx_frame_dropped),
		.drop_midpoint_event(mid), .mac_req(mac_req), .mac_cmd(mac_cmd), .mac_ack(mac_ack),
		.mac_rdata(mac_rdata), .tx_word(tx_word), .tx_word_ready(tx_word_ready),
		.tx_half(tx_half), .tx_half_ready(tx_half_ready), .rx_half(rx_half),
		.rx_word(rx_word));
	hmsr_mac_model mac (.sys_clk(sys_clk), .sys_rst(sys_rst), .mac_req(mac_req),
		.mac_cmd(mac_cmd), .lat(lat), .mac_ack(mac_ack), .mac_rdata(mac_rdata));
	always #5 sys_clk = ~sys_clk;
	// Midpoint pulse must not appear for small counts
	always @(posedge sys_clk) begin
		if (mid === 1'b1) begin
			saw_mid <= 1'b1;
		end
	end
	task automatic conclude;
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge sys_clk);
		#1 host_cs_n = 1'b0;
		host_wr_n = 1'b0;
		host_addr = a[7:1];
		host_din = x;
		@(posedge sys_clk);
		#1 host_cs_n = 1'b1;
		host_wr_n = 1'b1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge sys_clk);
		#1 host_cs_n = 1'b0;
		host_rd_n = 1'b0;
		host_addr = a[7:1];
		repeat (2) @(posedge sys_clk);
		#1 q = host_dout;
		chk("oe", 33'h000000001, {32'h00000000, oe});
		host_cs_n = 1'b1;
		host_rd_n = 1'b1;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a, d);
		chk(nm, {1'b0, e}, {1'b0, d});
	endtask : rdc
	task automatic idle;
		for (int i = 0; i < 40; i++) begin
			rd(8'ha4, d);
			if (d[31] === 1'b0) return;
		end
		chk("busy end", 33'h000000000, {1'b0, d});
	endtask : idle
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		rdc(8'h9c, 32'h00000000, "tick0");
		rd(8'h9c, v);
		repeat (9) @(posedge sys_clk);
		rd(8'h9c, d);
		chk("tick step", 33'h000000003, {1'b0, d - v});
		for (int i = 0; i < 7; i++) begin
			rdc(ra[i], i < 2 ? 32'h0000ffff : 32'h00000000, "reset");
		end
		repeat (3) begin
			@(posedge sys_clk);
			#1 rx_frame_dropped = 1'b1;
			@(posedge sys_clk);
			#1 rx_frame_dropped = 1'b0;
		end
		rdc(8'ha0, 32'h00000003, "drop");
		rdc(8'ha0, 32'h00000000, "drop clr");
		chk("no midpoint", 33'h000000000, {32'h00000000, saw_mid});
		wr(8'h8c, 32'h20000010);
		repeat (20) @(posedge sys_clk);
		wr(8'h8c, 32'h00000000);
		rdc(8'h8c, 32'h0000ffff, "preload");
		rd(8'h90, v);
		chk("tmr run", 33'h000000001, {32'h00000000, v < 32'h00000010});
		repeat (20) @(posedge sys_clk);
		rdc(8'h90, v, "tmr hold");
		bus_16bit = 1'b1;
		wr(8'ha8, 32'h00001234);
		wr(8'haa, 32'h0000abcd);
		// Snapshot pair, then a fresh snapshot closed by its second half
		rdc(8'h9e, 32'h00000000, "snap hi");
		repeat (20) @(posedge sys_clk);
		rd(8'h9c, d);
		rd(8'h9c, v);
		chk("snapshot", 33'h000000001, {32'h00000000, v[15:0] - d[15:0] > 16'h0004});
		rdc(8'h9e, 32'h00000000, "snap end");
		bus_16bit = 1'b0;
		rdc(8'ha8, 32'habcd1234, "order 0");
		bus_16bit = 1'b1;
		wr(8'h98, 32'h0000ffff);
		wr(8'h9a, 32'h0000ffff);
		wr(8'ha8, 32'h00005555);
		wr(8'haa, 32'h00006666);
		rdc(8'haa, 32'h00006666, "swap16");
		bus_16bit = 1'b0;
		rdc(8'ha8, 32'h55556666, "swap32");
		wr(8'ha8, 32'h11112222);
		rdc(8'ha8, 32'h11112222, "wide");
		wr(8'h98, 32'h00000000);
		wr(8'ha8, 32'hcafe0001);
		wr(8'ha4, 32'h80000012);
		idle();
		wr(8'ha8, 32'h00000000);
		lat = 8'h14;
		wr(8'ha4, 32'hc0ffff12);
		rdc(8'ha4, 32'hc0000012, "busy");
		wr(8'ha8, 32'h77777777);
		idle();
		rdc(8'ha8, 32'hcafe0001, "mac rd");
		rdc(8'ha4, 32'h40000012, "cmd");
		tx_word = {1'b1, 32'hbbbbaaaa};
		@(posedge sys_clk);
		#1 tx_word = {1'b1, 32'h44443333};
		chk("tx lo", {16'h0000, 17'h1aaaa}, {16'h0000, tx_half});
		chk("tx stall", 33'h000000000, {32'h00000000, tx_word_ready});
		@(posedge sys_clk);
		#1 tx_half_ready = 1'b1;
		@(posedge sys_clk);
		#1 chk("tx hi", {16'h0000, 17'h1bbbb}, {16'h0000, tx_half});
		@(posedge sys_clk);
		#1 tx_word = '0;
		chk("tx next", {16'h0000, 17'h13333}, {16'h0000, tx_half});
		tx_half_ready = 1'b0;
		rx_half = {1'b1, 16'h1111};
		@(posedge sys_clk);
		#1 rx_half = {1'b1, 16'h2222};
		@(posedge sys_clk);
		#1 rx_half = '0;
		chk("rx", {1'b1, 32'h22221111}, rx_word);
		conclude();
	end
endmodule : hmsr_regs_tb
